//--- logic/wcs_pkg.sv
// Package for the wake-cause status block: offsets, fields, reset values, types
package wcs_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] WCS_CTRL_OFF = 8'h00;
    localparam logic [7:0] WCS_CAUSE_OFF = 8'h04;
    localparam logic [7:0] WCS_IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] WCS_IRQ_MASK_OFF = 8'h0c;
    localparam logic [7:0] WCS_STATE_OFF = 8'h10;
    // Control register field positions
    localparam int WCS_ENERGY_EN_BIT = 0;
    localparam int WCS_LAN_EN_BIT = 1;
    localparam int WCS_RES_CLR_EN_BIT = 2;
    localparam int WCS_RES_CLR_CAUSE_BIT = 3;
    // Cause field positions
    localparam int WCS_CAUSE_ENERGY_BIT = 0;
    localparam int WCS_CAUSE_LAN_BIT = 1;
    // Interrupt status positions
    localparam int WCS_IRQ_ENERGY_BIT = 0;
    localparam int WCS_IRQ_LAN_BIT = 1;
    localparam int WCS_IRQ_RESUME_BIT = 2;
    // Reset values
    localparam logic [3:0] WCS_CTRL_RST = 4'h0;
    localparam logic [1:0] WCS_CAUSE_RST = 2'h0;
    localparam logic [2:0] WCS_IRQ_RST = 3'h0;

    // Power states of the device
    typedef enum logic [1:0] {
        WCS_AWAKE = 2'b00,
        WCS_SLEEP = 2'b01,
        WCS_RESUME = 2'b10
    } wcs_state_t;

    // Wake events from the link side
    typedef struct packed {
        logic energy;    // Energy detected on the line
        logic lan;       // Magic packet or good frame seen
    } wcs_event_t;

    // Power-management handshake with the device's suspend controller
    typedef struct packed {
        logic sleep_enter;   // Pulse: reduced-power state entered
        logic resume_done;   // Pulse: resume sequence complete
    } wcs_pm_t;
endpackage : wcs_pkg

//--- logic/wcs_cause_bit.sv
// One wake-cause bit: armed on sleep entry, sticky, write-one-to-clear
`timescale 1ns/1ns
module wcs_cause_bit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic enable,
    input wire logic sleep_enter,
    input wire logic event_in,
    input wire logic clear,
    // State
    output logic armed,
    output logic cause
);
    import wcs_pkg::*;

    // Enable is captured when the reduced-power state is entered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else if (sleep_enter) begin
            armed <= enable;
        end
    end

    // Sticky cause; a new event wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause <= 1'b0;
        end else if (event_in && armed) begin
            cause <= 1'b1;
        end else if (clear) begin
            cause <= 1'b0;
        end
    end

    a_cause_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cause) |-> $past(armed))
        else $error("Cause set without arming");
    a_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        cause && !clear |=> cause)
        else $error("Cause dropped without clear");
endmodule : wcs_cause_bit

//--- logic/wcs_top.sv
// Wake-cause status block with APB registers and interrupt
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module wcs_top (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power management and link events
    input wire wcs_pkg::wcs_pm_t pm,
    input wire wcs_pkg::wcs_event_t wake_evt,
    // Outputs
    output logic [1:0] wake_cause_bits,
    output logic irq
);
    import wcs_pkg::*;

    logic [3:0] ctrl_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [1:0] armed;
    logic [1:0] cause;
    logic [1:0] cause_clr;
    logic [1:0] evt;
    logic [1:0] en;
    wcs_state_t state_q;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] rdata_d;
    logic addr_ok;

    // Register decode shared by read and write paths
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : is_reg

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = is_reg(paddr, WCS_CTRL_OFF) || is_reg(paddr, WCS_CAUSE_OFF) ||
                     is_reg(paddr, WCS_IRQ_STAT_OFF) || is_reg(paddr, WCS_IRQ_MASK_OFF) ||
                     is_reg(paddr, WCS_STATE_OFF);
    assign pslverr = psel && penable && !addr_ok;

    // Control register; resume may auto-clear the wake enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= WCS_CTRL_RST;
        end else if (wr_acc && is_reg(paddr, WCS_CTRL_OFF)) begin
            ctrl_q <= pwdata[3:0];
        end else if (pm.resume_done && ctrl_q[WCS_RES_CLR_EN_BIT]) begin
            ctrl_q[WCS_ENERGY_EN_BIT] <= 1'b0;
            ctrl_q[WCS_LAN_EN_BIT] <= 1'b0;
        end
    end

    // Power state tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= WCS_AWAKE;
        end else begin
            case (state_q)
                WCS_AWAKE: begin
                    if (pm.sleep_enter) state_q <= WCS_SLEEP;
                end
                WCS_SLEEP: begin
                    if (evt != 2'b00) state_q <= WCS_RESUME;
                end
                WCS_RESUME: begin
                    if (pm.resume_done) state_q <= WCS_AWAKE;
                end
                default: state_q <= WCS_AWAKE;
            endcase
        end
    end

    // Per-bit event, enable and write-one clear
    assign evt = {wake_evt.lan, wake_evt.energy};
    assign en = {ctrl_q[WCS_LAN_EN_BIT], ctrl_q[WCS_ENERGY_EN_BIT]};
    assign cause_clr = (wr_acc && is_reg(paddr, WCS_CAUSE_OFF)) ? pwdata[1:0] : 2'b00;

    // Independent cause bits
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cause
            wcs_cause_bit u_bit (
                .pclk(pclk),
                .presetn(presetn),
                .enable(en[gi]),
                .sleep_enter(pm.sleep_enter),
                .event_in(evt[gi]),
                .clear(cause_clr[gi]),
                .armed(armed[gi]),
                .cause(cause[gi])
            );
        end
    endgenerate

    assign wake_cause_bits = cause;

    // Sticky interrupt status, cleared by reading it; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= WCS_IRQ_RST;
        end else begin
            irq_stat_q <= (rd_acc && is_reg(paddr, WCS_IRQ_STAT_OFF) ? 3'h0 : irq_stat_q) |
                          {pm.resume_done, evt & armed};
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= WCS_IRQ_RST;
        end else if (wr_acc && is_reg(paddr, WCS_IRQ_MASK_OFF)) begin
            irq_mask_q <= pwdata[2:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Read mux
    always_comb begin
        rdata_d = 32'h0;
        if (is_reg(paddr, WCS_CTRL_OFF)) rdata_d[3:0] = ctrl_q;
        if (is_reg(paddr, WCS_CAUSE_OFF)) rdata_d[1:0] = cause;
        if (is_reg(paddr, WCS_IRQ_STAT_OFF)) rdata_d[2:0] = irq_stat_q;
        if (is_reg(paddr, WCS_IRQ_MASK_OFF)) rdata_d[2:0] = irq_mask_q;
        if (is_reg(paddr, WCS_STATE_OFF)) rdata_d[3:0] = {armed, state_q};
    end

    // Read data register, loaded in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    a_enable_autoclear: assert property (@(posedge pclk) disable iff (!presetn)
        pm.resume_done && ctrl_q[WCS_RES_CLR_EN_BIT] && !wr_acc |=> ctrl_q[1:0] == 2'b00)
        else $error("Wake enables not cleared on resume");
    a_cause_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        cause_clr[0] && !(evt[0] && armed[0]) |=> !cause[0])
        else $error("Write one did not clear bit 0");
    a_cause_keep: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && is_reg(paddr, WCS_CAUSE_OFF) && pwdata[1:0] == 2'b01 && cause[1] |=> cause[1])
        else $error("Clearing bit 0 disturbed bit 1");
    a_both_record: assert property (@(posedge pclk) disable iff (!presetn)
        evt == 2'b11 && armed == 2'b11 |=> cause == 2'b11)
        else $error("Simultaneous events not both recorded");
    a_lan_maps: assert property (@(posedge pclk) disable iff (!presetn)
        wake_evt.lan && armed[1] |=> cause[1])
        else $error("LAN wake not on bit 1");
    a_unarmed_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !armed[0] && !cause[0] |=> !cause[0])
        else $error("Unarmed energy cause set");
    a_enable_free: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cause[1]) && !$past(cause_clr[1]) && $fell(ctrl_q[WCS_LAN_EN_BIT]) |-> cause[1])
        else $error("Cause lost with enable");
    a_reset_zero: assert property (@(posedge pclk) $rose(presetn) |-> cause == 2'b00)
        else $error("Cause not zero after reset");

    // Cause path: mapping, arming, clearing, read-back and independence of the two bits
    a_energy_maps: assert property (@(posedge pclk) disable iff (!presetn)
        wake_evt.energy && armed[0] |=> cause[0])
        else $error("Energy wake not on bit 0");
    a_lan_unarmed: assert property (@(posedge pclk) disable iff (!presetn)
        !armed[1] && !cause[1] |=> !cause[1])
        else $error("Unarmed LAN cause set");
    a_arm_capture: assert property (@(posedge pclk) disable iff (!presetn)
        pm.sleep_enter |=> armed == $past(en))
        else $error("Enables not captured on sleep entry");
    a_cause_w1c_hi: assert property (@(posedge pclk) disable iff (!presetn)
        cause_clr[1] && !(evt[1] && armed[1]) |=> !cause[1])
        else $error("Write one did not clear bit 1");
    a_write_zero: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && is_reg(paddr, WCS_CAUSE_OFF) && pwdata[1:0] == 2'b00 && cause == 2'b11 |=> cause == 2'b11)
        else $error("Writing zero disturbed a cause bit");
    a_lan_keeps_energy: assert property (@(posedge pclk) disable iff (!presetn)
        evt[1] && armed[1] && cause[0] && !cause_clr[0] |=> cause == 2'b11)
        else $error("LAN event disturbed energy cause");
    a_cause_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && is_reg(paddr, WCS_CAUSE_OFF) |=> prdata[1:0] == $past(cause))
        else $error("Cause read data wrong");

    // Control, interrupt, power-state and bus checks
    a_enables_kept: assert property (@(posedge pclk) disable iff (!presetn)
        pm.resume_done && !ctrl_q[WCS_RES_CLR_EN_BIT] && !wr_acc |=> $stable(ctrl_q))
        else $error("Enables changed on resume without auto-clear");
    a_stat_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && is_reg(paddr, WCS_IRQ_STAT_OFF) && !pm.resume_done && (evt & armed) == 2'b00
        |=> irq_stat_q == 3'h0)
        else $error("Interrupt status not cleared by read");
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && is_reg(paddr, WCS_IRQ_MASK_OFF) |=> irq_mask_q == $past(pwdata[2:0]))
        else $error("Mask write not taken");
    a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == WCS_AWAKE && pm.sleep_enter |=> state_q == WCS_SLEEP)
        else $error("Sleep entry not tracked");
    a_bad_addr_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr && pwrite && !pm.resume_done |=> $stable(ctrl_q) && $stable(irq_mask_q))
        else $error("Unmapped write changed a register");

    // Main scenarios
    c_energy_wake: cover property (@(posedge pclk) disable iff (!presetn) $rose(cause[0]));
    c_lan_wake: cover property (@(posedge pclk) disable iff (!presetn) $rose(cause[1]));
    c_both_wake: cover property (@(posedge pclk) disable iff (!presetn) cause == 2'b11);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_resume_clear: cover property (@(posedge pclk) disable iff (!presetn)
        pm.resume_done && ctrl_q[WCS_RES_CLR_EN_BIT]);
endmodule : wcs_top

//--- tb/wcs_host_model.sv
// Host-side APB master model that software accesses go through
`timescale 1ns/1ns
module wcs_host_model (
    // Clock and slave answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    logic err;

    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err = 1'b0;
    end

    // One transfer: setup, access held until pready, then release with scrambled lines
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
endmodule : wcs_host_model

//--- tb/tb_top.sv
// Self-checking bench for the wake-cause status block
`timescale 1ns/1ns
module tb_top;
    import wcs_pkg::*;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] wake_cause_bits;
    wcs_pm_t pm;
    wcs_event_t wake_evt;
    int num_errors = 0;
    int n_checks = 0;

    wcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pm(pm), .wake_evt(wake_evt), .wake_cause_bits(wake_cause_bits), .irq(irq));
    wcs_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // Clock at 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic wrap_up;
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        host.xfer(1'b0, a, 32'h0, q);
        chk(s, e, q);
    endtask : rd

    // One-cycle pulses: pm {sleep_enter, resume_done}, events {energy, lan}
    task automatic step(input logic [1:0] p, input logic [1:0] e);
        pm <= p;
        wake_evt <= e;
        @(posedge pclk);
        pm <= 2'b00;
        wake_evt <= 2'b00;
        @(posedge pclk);
    endtask : step

    // Watchdog against a hung handshake
    initial begin
        #40000;
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        pm = 2'b00;
        wake_evt = 2'b00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cause_port", 32'h0, {30'h0, wake_cause_bits});
        rd(WCS_CAUSE_OFF, 32'h0, "cause_rst");
        wr(WCS_CTRL_OFF, 32'h1);
        step(2'b10, 2'b00);
        step(2'b00, 2'b11);
        rd(WCS_CAUSE_OFF, 32'h1, "cause_energy");
        rd(WCS_STATE_OFF, 32'h6, "state_resume");
        wr(WCS_CTRL_OFF, 32'h2);
        step(2'b00, 2'b01);
        rd(WCS_CAUSE_OFF, 32'h1, "cause_keep");
        chk("cause_port", 32'h1, {30'h0, wake_cause_bits});
        wr(WCS_CAUSE_OFF, 32'h1);
        rd(WCS_CAUSE_OFF, 32'h0, "cause_clr");
        wr(WCS_CTRL_OFF, 32'h3);
        step(2'b10, 2'b00);
        step(2'b00, 2'b01);
        rd(WCS_CAUSE_OFF, 32'h2, "cause_lan");
        step(2'b00, 2'b10);
        rd(WCS_CAUSE_OFF, 32'h3, "cause_both");
        wr(WCS_CAUSE_OFF, 32'h0);
        rd(WCS_CAUSE_OFF, 32'h3, "cause_w0");
        wr(WCS_CAUSE_OFF, 32'h2);
        rd(WCS_CAUSE_OFF, 32'h1, "cause_w1_lan");
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(WCS_IRQ_MASK_OFF, 32'h3);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd(WCS_IRQ_STAT_OFF, 32'h3, "irq_stat");
        chk("irq_off", 32'h0, {31'h0, irq});
        rd(WCS_IRQ_STAT_OFF, 32'h0, "irq_stat_clr");
        wr(WCS_CTRL_OFF, 32'h7);
        step(2'b01, 2'b00);
        rd(WCS_CTRL_OFF, 32'h4, "ctrl_resume");
        rd(WCS_IRQ_STAT_OFF, 32'h4, "irq_resume");
        wr(WCS_CTRL_OFF, 32'h3);
        step(2'b01, 2'b00);
        rd(WCS_CTRL_OFF, 32'h3, "ctrl_keep");
        step(2'b00, 2'b11);
        wr(WCS_CTRL_OFF, 32'h0);
        rd(WCS_CAUSE_OFF, 32'h3, "cause_enable_off");
        wr(WCS_CAUSE_OFF, 32'h1);
        rd(WCS_CAUSE_OFF, 32'h2, "cause_w1_energy");
        chk("pready", 32'h1, {31'h0, pready});
        chk("slverr_ok", 32'h0, {31'h0, host.err});
        rd(8'h20, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, host.err});
        wr(8'h20, 32'h3);
        chk("slverr_wr", 32'h1, {31'h0, host.err});
        rd(WCS_CTRL_OFF, 32'h0, "ctrl_refused");
        // Reset again in mid-run with causes and status recorded
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cause_port_rst", 32'h0, {30'h0, wake_cause_bits});
        rd(WCS_IRQ_STAT_OFF, 32'h0, "irq_stat_rst");
        wrap_up();
    end
endmodule : tb_top
